//--- rtl/iapr_pkg.sv
// constants, lookup table and helpers for the address/rate prescaler block
// assumes registers sit at byte offsets from the peripheral base
package iapr_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [9:0] OFF_OWN_ADDR = 10'h280;
    localparam logic [9:0] OFF_PRESCALE = 10'h284;
    localparam logic [9:0] OFF_CONTROL = 10'h288;
    localparam logic [9:0] OFF_STATUS = 10'h28C;
    localparam logic [9:0] OFF_DATA_IO = 10'h290;
    localparam int BYTE_LSB = 24;
    localparam int OWN_ADDR_LSB = 1;
    localparam int CTL_ENABLE_BIT = 7;
    localparam int STS_MATCH_BIT = 6;
    localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
    localparam logic [5:0] RATE_RESET = 6'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] IDX_OWN = 3'h0;
    localparam logic [2:0] IDX_RATE = 3'h1;
    localparam logic [2:0] IDX_CTL = 3'h2;
    localparam logic [2:0] IDX_STS = 3'h3;
    localparam logic [2:0] IDX_DATA = 3'h4;
    localparam logic [2:0] IDX_NONE = 3'h7;
    localparam logic [3:0] ADDR_BITS = 4'h8;

    // ****************************************
    // divider per rate code
    // ****************************************
    localparam logic [11:0] DIV_TABLE [64] = '{
        12'h01C, 12'h01E, 12'h022, 12'h028, 12'h02C, 12'h030, 12'h038, 12'h044,
        12'h050, 12'h058, 12'h068, 12'h080, 12'h090, 12'h0A0, 12'h0C0, 12'h0F0,
        12'h120, 12'h140, 12'h180, 12'h1E0, 12'h240, 12'h280, 12'h300, 12'h3C0,
        12'h480, 12'h500, 12'h600, 12'h780, 12'h900, 12'hA00, 12'hC00, 12'hF00,
        12'h014, 12'h016, 12'h018, 12'h01A, 12'h01C, 12'h020, 12'h024, 12'h028,
        12'h030, 12'h038, 12'h040, 12'h048, 12'h050, 12'h060, 12'h070, 12'h080,
        12'h0A0, 12'h0C0, 12'h0E0, 12'h100, 12'h140, 12'h180, 12'h1C0, 12'h200,
        12'h280, 12'h300, 12'h380, 12'h400, 12'h500, 12'h600, 12'h700, 12'h800
    };

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_ACK = 2'b10
    } iapr_state_t;

    // word-aligned offset to register index; anything else is a miss
    function automatic logic [2:0] reg_index(input logic [9:0] a);
        logic [9:0] d;
        d = a - OFF_OWN_ADDR;
        if (a < OFF_OWN_ADDR || a > OFF_DATA_IO || a[1:0] != 2'h0) begin
            return IDX_NONE;
        end
        return d[4:2];
    endfunction

endpackage

//--- rtl/iapr_prescaler.sv
// rate divider: bit tick every divider cycles, four sample ticks per bit
// assumes rate_code is a register on the same clock
`timescale 1ns/1ps
module iapr_prescaler (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [5:0] rate_code,
    output logic sample_tick,
    output logic bit_tick,
    output logic bit_clock
);
    import iapr_pkg::*;

    logic [11:0] cnt;
    wire [11:0] div = DIV_TABLE[rate_code];
    wire [11:0] quarter = {2'h0, div[11:2]};
    wire [11:0] half = {1'h0, div[11:1]};
    // >= so that a smaller code written mid-count wraps at once
    wire last = cnt >= div - 12'h001;
    wire [11:0] next_cnt = last ? 12'h000 : cnt + 12'h001;
    wire next_sample = cnt == 12'h000 || cnt == quarter || cnt == half ||
                       cnt == quarter + half;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 12'h000;
            sample_tick <= 1'b0;
            bit_tick <= 1'b0;
            bit_clock <= 1'b0;
        end else if (ce) begin
            cnt <= next_cnt;
            sample_tick <= next_sample;
            bit_tick <= last;
            bit_clock <= cnt < half;
        end
    end

    // the count made under a code may exceed the next code's divider,
    // so only a count made under the code still in force is bounded
    property p_cnt_bound;
        @(posedge clk) disable iff (!resetn)
        ce ##1 $stable(rate_code) |-> cnt < div;
    endproperty
    a_cnt_bound: assert property (p_cnt_bound)
        else $error("prescaler count beyond divider");

    property p_tick_period;
        @(posedge clk) disable iff (!resetn)
        ce && last && rate_code == 6'h20 && $stable(rate_code)
        |=> (ce && rate_code == 6'h20)[*8] ##1 (cnt == 12'h008 || !ce
            || rate_code != 6'h20);
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("divider period wrong for code 20");
endmodule

//--- rtl/iapr_top.sv
// own-address register, rate prescaler and register map of a two-wire
// bus controller; cpu and on-bus master share the five registers
// assumes scl_in/sda_in are raw pins and the open-drain wire is resolved
// outside from sda_oe_n
`timescale 1ns/1ps
module iapr_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic cpu_sel,
    input wire logic cpu_wr,
    input wire logic [9:0] cpu_addr,
    input wire logic [31:0] cpu_wdata,
    output logic [31:0] cpu_rdata,
    output logic cpu_rvalid,
    input wire logic ext_sel,
    input wire logic ext_wr,
    input wire logic [9:0] ext_addr,
    input wire logic [7:0] ext_wdata,
    output logic [7:0] ext_rdata,
    output logic ext_rvalid,
    input wire logic [7:0] status_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic [7:0] bus_control,
    output logic [7:0] bus_data_io,
    output logic [5:0] rate_code,
    output logic addr_match,
    output logic slave_rw
);
    import iapr_pkg::*;

    // ****************************************
    // registers and access decode
    // ****************************************
    logic [6:0] own_slave_address;
    wire [2:0] cpu_idx = reg_index(cpu_addr);
    wire [2:0] ext_idx = reg_index(ext_addr);
    wire [7:0] cpu_byte = cpu_wdata[BYTE_LSB +: 8];
    wire cpu_we = cpu_sel && cpu_wr;
    wire ext_we = ext_sel && ext_wr;
    // cpu wins a same-cycle write to the same register
    wire ext_ok = !(cpu_we && cpu_idx == ext_idx);
    wire [7:0] status_rd = status_in | (8'h01 << STS_MATCH_BIT) &
                           {8{addr_match}};

    function automatic logic [7:0] read_byte(input logic [2:0] idx);
        unique case (idx)
            IDX_OWN: return {own_slave_address, 1'b0};
            IDX_RATE: return {2'h0, rate_code};
            IDX_CTL: return bus_control;
            IDX_STS: return status_rd;
            IDX_DATA: return bus_data_io;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] pick(input logic [2:0] idx,
                                        input logic [7:0] old);
        if (cpu_we && cpu_idx == idx) begin
            return cpu_byte;
        end
        if (ext_we && ext_ok && ext_idx == idx) begin
            return ext_wdata;
        end
        return old;
    endfunction

    wire [7:0] next_own = pick(IDX_OWN, {own_slave_address, 1'b0});
    wire [7:0] next_rate = pick(IDX_RATE, {2'h0, rate_code});
    wire [7:0] next_ctl = pick(IDX_CTL, bus_control);
    wire [7:0] next_data = pick(IDX_DATA, bus_data_io);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            own_slave_address <= OWN_ADDR_RESET;
            rate_code <= RATE_RESET;
            bus_control <= BYTE_RESET;
            bus_data_io <= BYTE_RESET;
            cpu_rdata <= 32'h0000_0000;
            cpu_rvalid <= 1'b0;
            ext_rdata <= BYTE_RESET;
            ext_rvalid <= 1'b0;
        end else if (ce) begin
            own_slave_address <= next_own[7:OWN_ADDR_LSB];
            rate_code <= next_rate[5:0];
            bus_control <= next_ctl;
            bus_data_io <= next_data;
            cpu_rdata <= {read_byte(cpu_idx), 24'h00_0000};
            cpu_rvalid <= cpu_sel && !cpu_wr;
            ext_rdata <= read_byte(ext_idx);
            ext_rvalid <= ext_sel && !ext_wr;
        end
    end

    // ****************************************
    // pin sampling
    // ****************************************
    logic sample_tick;
    iapr_prescaler u_pre (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .rate_code(rate_code),
        .sample_tick(sample_tick),
        .bit_tick(),
        .bit_clock()
    );

    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic scl_f, sda_f, scl_q, sda_q, scl_p, sda_p;
    // slow edges can bounce; only a level held by the last two stages counts
    wire next_scl_f = scl_sync[1] == scl_sync[2] ? scl_sync[2] : scl_f;
    wire next_sda_f = sda_sync[1] == sda_sync[2] ? sda_sync[2] : sda_f;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else if (ce) begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            scl_f <= next_scl_f;
            sda_f <= next_sda_f;
            if (sample_tick) begin
                scl_q <= scl_f;
                sda_q <= sda_f;
                scl_p <= scl_q;
                sda_p <= sda_q;
            end
        end
    end

    // ****************************************
    // calling address match
    // ****************************************
    wire ev = ce && sample_tick;
    wire start_ev = scl_q && scl_p && sda_p && !sda_q;
    wire stop_ev = scl_q && scl_p && !sda_p && sda_q;
    wire scl_rise = scl_q && !scl_p;
    wire scl_fall = !scl_q && scl_p;
    wire enabled = bus_control[CTL_ENABLE_BIT];

    iapr_state_t state, next_state;
    logic [7:0] shift;
    logic [3:0] bits;
    // own address feeds this comparator and the read-back data of both register paths
    wire hit = shift[7:1] == own_slave_address;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: ;
            ST_ADDR: begin
                if (scl_fall && bits == ADDR_BITS) begin
                    next_state = hit && enabled ? ST_ACK : ST_IDLE;
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (start_ev && enabled) begin
            next_state = ST_ADDR;
        end else if (stop_ev) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            shift <= 8'h00;
            bits <= 4'h0;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
            addr_match <= 1'b0;
            slave_rw <= 1'b0;
        end else if (ev) begin
            state <= next_state;
            sda_oe_n <= next_state != ST_ACK;
            if (start_ev) begin
                bits <= 4'h0;
                addr_match <= 1'b0;
            end else if (state == ST_ADDR && scl_rise) begin
                shift <= {shift[6:0], sda_q};
                bits <= bits + 4'h1;
            end
            if (state == ST_ADDR && next_state == ST_ACK) begin
                addr_match <= 1'b1;
                slave_rw <= shift[0];
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_own_write;
        ce && cpu_we && cpu_idx == IDX_OWN && !(ext_we && ext_idx == IDX_OWN);
    endsequence
    sequence s_own_read;
        ce && cpu_sel && !cpu_wr && cpu_idx == IDX_OWN;
    endsequence

    property p_own_rw;
        @(posedge clk) disable iff (!resetn)
        s_own_write ##1 s_own_read |=>
        cpu_rdata[31:24] == {$past(cpu_wdata[31:25], 2), 1'b0};
    endproperty
    a_own_rw: assert property (p_own_rw)
        else $error("own address read back wrong");

    property p_low_bytes;
        @(posedge clk) disable iff (!resetn)
        cpu_rvalid |-> cpu_rdata[23:0] == 24'h00_0000;
    endproperty
    a_low_bytes: assert property (p_low_bytes)
        else $error("reserved bytes not zero");

    property p_ext_miss;
        @(posedge clk) disable iff (!resetn)
        ce && ext_sel && !ext_wr && ext_idx == IDX_NONE |=> ext_rdata == 8'h00;
    endproperty
    a_ext_miss: assert property (p_ext_miss)
        else $error("external read outside the block returned data");

    property p_ext_rate;
        @(posedge clk) disable iff (!resetn)
        ce && ext_we && ext_idx == IDX_RATE && !(cpu_we && cpu_idx == IDX_RATE)
        |=> rate_code == $past(ext_wdata[5:0]);
    endproperty
    a_ext_rate: assert property (p_ext_rate)
        else $error("external rate write lost");

    property p_rate_write;
        @(posedge clk) disable iff (!resetn)
        ce && cpu_we && cpu_idx == IDX_RATE |=>
        rate_code == $past(cpu_wdata[29:24]);
    endproperty
    a_rate_write: assert property (p_rate_write)
        else $error("rate code not taken");

    property p_sample_only;
        @(posedge clk) disable iff (!resetn)
        !(ce && sample_tick) |=> $stable(scl_q) && $stable(sda_q);
    endproperty
    a_sample_only: assert property (p_sample_only)
        else $error("lines sampled off the prescaler tick");

    property p_ack_drive;
        @(posedge clk) disable iff (!resetn)
        ev && state == ST_ADDR && scl_fall && bits == ADDR_BITS && hit &&
        enabled && !start_ev && !stop_ev |=> !sda_oe_n && !sda_out && addr_match;
    endproperty
    a_ack_drive: assert property (p_ack_drive)
        else $error("no acknowledge on address match");

    property p_drive_only_ack;
        @(posedge clk) disable iff (!resetn)
        !sda_oe_n |-> state == ST_ACK;
    endproperty
    a_drive_only_ack: assert property (p_drive_only_ack)
        else $error("data driven outside the acknowledge");

    property p_no_match_quiet;
        @(posedge clk) disable iff (!resetn)
        ev && state == ST_ADDR && scl_fall && bits == ADDR_BITS && !hit &&
        !start_ev |=> sda_oe_n && state == ST_IDLE;
    endproperty
    a_no_match_quiet: assert property (p_no_match_quiet)
        else $error("answered a foreign address");
endmodule

//--- tb/iapr_bus_master_model.sv
// two-wire bus master model: start, one byte with ninth-clock ack, stop
// assumes the bench resolves the open-drain data wire into sda_line
`timescale 1ns/1ps
module iapr_bus_master_model #(
    parameter int HALF = 80
) (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // ****************************************
    // bus phases
    // ****************************************
    // data moves only in the middle of the low phase, so no false start
    task automatic bit_cycle(input logic v, output logic seen);
        repeat (HALF / 2) @(posedge clk);
        sda <= v;
        repeat (HALF / 2) @(posedge clk);
        scl <= 1'b1;
        repeat (HALF / 2) @(posedge clk);
        #1 seen = sda_line;
        repeat (HALF / 2) @(posedge clk);
        scl <= 1'b0;
    endtask

    task automatic start();
        repeat (HALF) @(posedge clk);
        sda <= 1'b0;
        repeat (HALF) @(posedge clk);
        scl <= 1'b0;
    endtask

    // clash flags an address bit that the line did not carry as sent
    task automatic send_byte(input logic [7:0] b, output logic ack,
                             output logic clash);
        logic s;
        clash = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
            if (s !== b[i]) clash = 1'b1;
        end
        bit_cycle(1'b1, s);
        ack = (s === 1'b0);
    endtask

    task automatic stop();
        repeat (HALF / 2) @(posedge clk);
        sda <= 1'b0;
        repeat (HALF / 2) @(posedge clk);
        scl <= 1'b1;
        repeat (HALF) @(posedge clk);
        sda <= 1'b1;
    endtask
endmodule

//--- tb/iapr_top_tb.sv
// bench: register map on both access paths, slave call acknowledge via
// the master model, and the divider table seen through the top's prescaler
// assumes one 40 MHz clock and an active-low asynchronous reset
`timescale 1ns/1ps
module iapr_top_tb;
    import iapr_pkg::*;
    logic clk, resetn, ce, cpu_sel, cpu_wr, ext_sel, ext_wr;
    logic [9:0] cpu_addr, ext_addr;
    logic [31:0] cpu_wdata, cpu_rdata, q;
    logic [7:0] ext_wdata, ext_rdata, status_in, bus_control, bus_data_io;
    logic cpu_rvalid, ext_rvalid, scl_m, sda_m, sda_in, sda_out, sda_oe_n;
    logic [5:0] rate_code;
    logic addr_match, slave_rw, ack, clash;
    int num_errors = 0;
    int compares = 0;
    logic [11:0] exp_div [64] = '{
        12'h01C, 12'h01E, 12'h022, 12'h028, 12'h02C, 12'h030, 12'h038, 12'h044,
        12'h050, 12'h058, 12'h068, 12'h080, 12'h090, 12'h0A0, 12'h0C0, 12'h0F0,
        12'h120, 12'h140, 12'h180, 12'h1E0, 12'h240, 12'h280, 12'h300, 12'h3C0,
        12'h480, 12'h500, 12'h600, 12'h780, 12'h900, 12'hA00, 12'hC00, 12'hF00,
        12'h014, 12'h016, 12'h018, 12'h01A, 12'h01C, 12'h020, 12'h024, 12'h028,
        12'h030, 12'h038, 12'h040, 12'h048, 12'h050, 12'h060, 12'h070, 12'h080,
        12'h0A0, 12'h0C0, 12'h0E0, 12'h100, 12'h140, 12'h180, 12'h1C0, 12'h200,
        12'h280, 12'h300, 12'h380, 12'h400, 12'h500, 12'h600, 12'h700, 12'h800
    };

    // wired-and data line with pull-up
    assign sda_in = sda_m & (sda_oe_n | sda_out);

    iapr_top i_iapr_top (.clk(clk), .resetn(resetn), .ce(ce),
        .cpu_sel(cpu_sel), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
        .ext_sel(ext_sel), .ext_wr(ext_wr), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .ext_rvalid(ext_rvalid),
        .status_in(status_in), .scl_in(scl_m), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .bus_control(bus_control),
        .bus_data_io(bus_data_io), .rate_code(rate_code),
        .addr_match(addr_match), .slave_rw(slave_rw));
    iapr_bus_master_model #(.HALF(80)) i_iapr_bus_master_model (.clk(clk),
        .sda_line(sda_in), .scl(scl_m), .sda(sda_m));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic final_report();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one access on either path; entered and left on a rising edge
    task automatic acc(input logic ext, input logic wr, input logic [9:0] a,
                       input logic [7:0] d, output logic [31:0] r);
        ext_sel <= ext;
        cpu_sel <= !ext;
        ext_wr <= wr;
        cpu_wr <= wr;
        ext_addr <= a;
        cpu_addr <= a;
        ext_wdata <= d;
        cpu_wdata <= {d, 24'h000000};
        @(posedge clk);
        cpu_sel <= 1'b0;
        ext_sel <= 1'b0;
        #1;
        r = ext ? {ext_rdata, 24'h000000} : cpu_rdata;
        if (!wr) check("read valid", ext ? ext_rvalid : cpu_rvalid, 1);
        @(posedge clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_regs();
        acc(0, 0, OFF_OWN_ADDR, 8'h00, q);
        check("own reset", q, 32'h00000000);
        // write then read in the very next cycle, no gap between them
        cpu_sel <= 1'b1;
        cpu_wr <= 1'b1;
        cpu_addr <= OFF_OWN_ADDR;
        cpu_wdata <= 32'h3C00_0000;
        @(posedge clk);
        cpu_wr <= 1'b0;
        @(posedge clk);
        cpu_sel <= 1'b0;
        #1;
        check("own back to back", cpu_rdata, 32'h3C000000);
        @(posedge clk);
        acc(0, 1, OFF_OWN_ADDR, 8'hA4, q);
        acc(1, 0, OFF_OWN_ADDR, 8'h00, q);
        check("ext own", q, 32'hA4000000);
        acc(1, 1, OFF_CONTROL, 8'h80, q);
        acc(0, 0, OFF_CONTROL, 8'h00, q);
        check("control", q, 32'h80000000);
        check("control out", bus_control, 32'h00000080);
        acc(1, 1, OFF_PRESCALE, 8'h20, q);
        check("rate code", rate_code, 32'h00000020);
        acc(0, 1, OFF_DATA_IO, 8'h5A, q);
        acc(1, 1, 10'h294, 8'hFF, q);
        acc(1, 0, 10'h294, 8'h00, q);
        check("ext miss", q, 32'h00000000);
        acc(0, 0, OFF_DATA_IO, 8'h00, q);
        check("data", q, 32'h5A000000);
        check("data out", bus_data_io, 32'h0000005A);
        status_in <= 8'h11;
        acc(0, 0, OFF_STATUS, 8'h00, q);
        check("status", q, 32'h11000000);
        acc(0, 0, 10'h281, 8'h00, q);
        check("unaligned", q, 32'h00000000);
    endtask

    task automatic call(input logic [7:0] b, input logic exp_ack);
        i_iapr_bus_master_model.start();
        i_iapr_bus_master_model.send_byte(b, ack, clash);
        check("ack", ack, exp_ack);
        check("address clash", clash, 0);
        check("match", addr_match, exp_ack);
        i_iapr_bus_master_model.stop();
        check("released", sda_oe_n, 1);
        check("drive level", sda_out, 0);
    endtask

    task automatic test_slave();
        call(8'hA5, 1'b1);
        check("read bit", slave_rw, 1);
        acc(0, 0, OFF_STATUS, 8'h00, q);
        check("match status", q, 32'h51000000);
        call(8'h30, 1'b0);
        acc(0, 1, OFF_CONTROL, 8'h00, q);
        call(8'hA4, 1'b0);
    endtask

    task automatic wait_tick(output int n, output int s);
        n = 0;
        s = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            s += int'(i_iapr_top.u_pre.sample_tick);
        end while (i_iapr_top.u_pre.bit_tick !== 1'b1 && n < 4000);
    endtask

    // code changes mid-run; the period after the first tick must follow
    task automatic test_rates();
        int n;
        int s;
        for (int c = 0; c < 64; c++) begin
            @(posedge clk);
            acc(0, 1, OFF_PRESCALE, 8'(c), q);
            check("swept code", rate_code, 32'(c));
            wait_tick(n, s);
            wait_tick(n, s);
            check("divider", n, 32'(exp_div[c]));
            check("samples per bit", s, 4);
        end
    endtask

    // ****************************************
    // clock, reset, sequence, watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        {cpu_sel, cpu_wr, ext_sel, ext_wr} = 4'h0;
        cpu_addr = 10'h000;
        ext_addr = 10'h000;
        cpu_wdata = 32'h00000000;
        ext_wdata = 8'h00;
        status_in = 8'h00;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        test_regs();
        test_slave();
        test_rates();
        final_report();
    end

    // the divider sweep alone needs up to about 74000 cycles
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        final_report();
    end
endmodule
